// [pkg/lpm_pkg.sv]
/*
 * constants, state and carrier types of the low power mode controller.
 * assumes one 200 MHz clock and an AXI4-Lite register port.
 */
package lpm_pkg;
  // register byte addresses
  localparam logic [7:0] LPM_CTRL_ADDR = 8'h00;
  localparam logic [7:0] LPM_STAT_ADDR = 8'h04;
  // control field positions
  localparam int LPM_TB_BIT   = 0;
  localparam int LPM_WRAP_BIT = 1;
  localparam int LPM_SLO_BIT  = 2;
  localparam int LPM_SHI_BIT  = 3;
  localparam int LPM_AWU_BIT  = 4;
  localparam logic [4:0] LPM_CTRL_RST = 5'h00;
  // opcodes and timing
  localparam logic [7:0] LPM_OP_HALT  = 8'h8E;
  localparam int         LPM_STAB_CYC = 256;
  localparam logic [8:0] LPM_STAB_END = 9'(LPM_STAB_CYC - 1);
  // bus answers
  localparam logic [1:0] LPM_OKAY   = 2'h0;
  localparam logic [1:0] LPM_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b000,
    ST_WAIT = 3'b001,
    ST_AH   = 3'b010,
    ST_HALT = 3'b011,
    ST_STAB = 3'b100,
    ST_AWU  = 3'b101
  } lpm_state_t;

  // clock enables handed to the clock tree
  typedef struct packed {
    logic cpu;
    logic periph;
    logic osc;
    logic timer;
  } lpm_clk_t;

  // whole state of the controller
  typedef struct packed {
    lpm_state_t  st;
    logic [8:0]  cnt;
    logic        by_rst;
    logic [4:0]  ctl;
    logic        s1;
    logic        s2;
    logic        mclr;
    logic        srv;
    logic        fetch;
    logic        wrst;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lpm_st_t;

  localparam lpm_st_t LPM_ST_RST = '0;
endpackage

// [core/lpm_ctrl.sv]
/*
 * low power mode controller: run, wait, active-halt, halt, auto-wake halt.
 * assumes the cpu core presents executed opcodes, the interrupt logic
 * gives qualified wake levels on aclk, and the wake reset is a raw pin.
 */
`timescale 1ns/10ps
module lpm_ctrl #(
  parameter logic [7:0] IDLE_OP = 8'h8F  // idle opcode, value arbitrary
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      awaddr,
  input  wire logic            awvalid,
  output      logic            awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output      logic            wready,
  output      logic [1:0]      bresp,
  output      logic            bvalid,
  input  wire logic            bready,
  input  wire logic [7:0]      araddr,
  input  wire logic            arvalid,
  output      logic            arready,
  output      logic [31:0]     rdata,
  output      logic [1:0]      rresp,
  output      logic            rvalid,
  input  wire logic            rready,
  input  wire logic            op_valid,
  input  wire logic [7:0]      opcode,
  input  wire logic            wdg_on,
  input  wire logic            dog_sleep_option,
  input  wire logic            wake_rst_pin,
  input  wire logic            irq_any,
  input  wire logic            irq_halt_exit,
  input  wire logic            irq_rtc,
  input  wire logic            irq_wrap,
  output lpm_pkg::lpm_clk_t    clk_en,
  output      logic            mask_clr,
  output      logic            irq_enter,
  output      logic            fetch_rst,
  output      logic            wdg_rst,
  output      logic [2:0]      mode
);

  ////////////////////////////////////////////////////////////////////////
  // state and decode

  lpm_pkg::lpm_st_t q;       // registered state
  lpm_pkg::lpm_st_t d;       // next state
  logic             ah_en;   // active-halt selected by timer bits
  logic             is_idle; // idle op executed
  logic             is_halt; // halt op executed
  logic             dog_hit; // halt turns into watchdog reset
  logic             aw_go;   // write taken
  logic             ar_go;   // read taken

  // besides LPM_TB_BIT, only the overflow path with the middle clock choice keeps the big timer
  assign ah_en = q.ctl[lpm_pkg::LPM_TB_BIT] |
                 (q.ctl[lpm_pkg::LPM_WRAP_BIT] & ~q.ctl[lpm_pkg::LPM_SHI_BIT] &
                  q.ctl[lpm_pkg::LPM_SLO_BIT]);
  // opcodes are decoded always; only the run state acts on them
  assign is_idle = op_valid & (opcode == IDLE_OP);
  assign is_halt = op_valid & (opcode == lpm_pkg::LPM_OP_HALT);
  // an enabled active-halt keeps the watchdog quiet
  assign dog_hit = wdg_on & ~dog_sleep_option & ~ah_en;
  // both channels are taken together; one answer outstanding at a time
  assign aw_go   = awvalid & wvalid & ~q.bvalid;
  assign ar_go   = arvalid & ~q.rvalid;

  ////////////////////////////////////////////////////////////////////////
  // next state

  // one copy of the whole state is filled here, the register only latches it;
  // wake events are looked at only in the mode that owns them
  always_comb begin
    d       = q;
    d.mclr  = 1'b0;
    d.srv   = 1'b0;
    d.fetch = 1'b0;
    d.wrst  = 1'b0;
    // wake reset pin synchroniser
    d.s1    = wake_rst_pin;
    d.s2    = q.s1;
    case (q.st)
      lpm_pkg::ST_RUN: begin
        // nothing but the mask bit is touched on entry
        if (is_idle) begin
          d.st   = lpm_pkg::ST_WAIT;
          d.mclr = 1'b1;
        end else if (is_halt && dog_hit) begin
          d.wrst = 1'b1;
        end else if (is_halt) begin
          d.mclr = 1'b1;
          if (ah_en) begin
            d.st = lpm_pkg::ST_AH;
          end else if (q.ctl[lpm_pkg::LPM_AWU_BIT]) begin
            d.st = lpm_pkg::ST_AWU;
          end else begin
            d.st = lpm_pkg::ST_HALT;
          end
        end
      end
      lpm_pkg::ST_WAIT: begin
        // clock still runs, so reset needs no settling time
        if (q.s2) begin
          d.st    = lpm_pkg::ST_RUN;
          d.fetch = 1'b1;
        end else if (irq_any) begin
          d.st  = lpm_pkg::ST_RUN;
          d.srv = 1'b1;
        end
      end
      lpm_pkg::ST_AH: begin
        // a pending timer irq at entry wakes on the first cycle
        if (q.s2) begin
          d.st     = lpm_pkg::ST_STAB;
          d.by_rst = 1'b1;
          d.cnt    = '0;
        end else if (irq_rtc || irq_wrap) begin
          d.st  = lpm_pkg::ST_RUN;
          d.srv = 1'b1;
        end
      end
      lpm_pkg::ST_HALT, lpm_pkg::ST_AWU: begin
        // the oscillator restarts at once; settling hides its start from the cpu
        if (q.s2) begin
          d.st     = lpm_pkg::ST_STAB;
          d.by_rst = 1'b1;
          d.cnt    = '0;
        end else if (irq_halt_exit) begin
          d.st     = lpm_pkg::ST_STAB;
          d.by_rst = 1'b0;
          d.cnt    = '0;
        end
      end
      lpm_pkg::ST_STAB: begin
        // oscillator settles for a fixed count before the cpu restarts
        // the count runs from zero to its end value, one cycle per step
        if (q.cnt == lpm_pkg::LPM_STAB_END) begin
          d.st    = lpm_pkg::ST_RUN;
          d.fetch = q.by_rst;
          d.srv   = ~q.by_rst;
        end else begin
          d.cnt = q.cnt + 9'h001;
        end
      end
      default: begin
        // unused codes fall back to run rather than lock the cpu out
        d.st = lpm_pkg::ST_RUN;
      end
    endcase
    // register writes
    // one answer outstanding: a new write waits until bready retires it
    if (aw_go) begin
      d.bvalid = 1'b1;
      if (awaddr == lpm_pkg::LPM_CTRL_ADDR) begin
        d.bresp = lpm_pkg::LPM_OKAY;
        if (wstrb[0]) begin
          d.ctl = wdata[4:0];
        end
      end else if (awaddr == lpm_pkg::LPM_STAT_ADDR) begin
        d.bresp = lpm_pkg::LPM_OKAY;  // read-only, write dropped
      end else begin
        d.bresp = lpm_pkg::LPM_SLVERR;
      end
    end else if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    // register reads
    // read data is captured when taken and stands until rready
    if (ar_go) begin
      d.rvalid = 1'b1;
      d.rresp  = lpm_pkg::LPM_OKAY;
      if (araddr == lpm_pkg::LPM_CTRL_ADDR) begin
        d.rdata = {27'h0000000, q.ctl};
      end else if (araddr == lpm_pkg::LPM_STAT_ADDR) begin
        d.rdata = {27'h0000000, ah_en, q.by_rst, q.st};
      end else begin
        d.rdata = 32'h00000000;
        d.rresp = lpm_pkg::LPM_SLVERR;
      end
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset returns every field, the pin synchroniser too, to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= lpm_pkg::LPM_ST_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // clock gating follows the mode alone; decoding the state register gives
  // the enables at no extra flip-flop; moves that flip several state bits, as ST_HALT to ST_STAB, can glitch them
  always_comb begin
    clk_en.cpu    = (q.st == lpm_pkg::ST_RUN);
    clk_en.periph = (q.st == lpm_pkg::ST_RUN) || (q.st == lpm_pkg::ST_WAIT);
    clk_en.osc    = (q.st != lpm_pkg::ST_HALT) && (q.st != lpm_pkg::ST_AWU);
    clk_en.timer  = clk_en.osc;
  end

  // handshake readies and clk_en are combinational, every other output is a flip-flop
  assign awready   = aw_go;
  assign wready    = aw_go;
  assign arready   = ~q.rvalid;
  assign bvalid    = q.bvalid;
  assign bresp     = q.bresp;
  assign rvalid    = q.rvalid;
  assign rdata     = q.rdata;
  assign rresp     = q.rresp;
  assign mask_clr  = q.mclr;
  assign irq_enter = q.srv;
  assign fetch_rst = q.fetch;
  assign wdg_rst   = q.wrst;
  assign mode      = q.st;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // entry into each sleep mode from run
  idle_entry_a: assert property (q.st == lpm_pkg::ST_RUN && is_idle |=>
    q.st == lpm_pkg::ST_WAIT && mask_clr && !clk_en.cpu && clk_en.periph)
    else $error("idle op did not enter wait");
  ah_pick_a: assert property (q.st == lpm_pkg::ST_RUN && is_halt && ah_en
    |=> q.st == lpm_pkg::ST_AH && mask_clr)
    else $error("halt did not enter active-halt");
  plain_halt_a: assert property (q.st == lpm_pkg::ST_RUN && is_halt && !dog_hit
    && !ah_en && !q.ctl[lpm_pkg::LPM_AWU_BIT] |=> q.st == lpm_pkg::ST_HALT)
    else $error("halt did not enter halt");
  self_wake_a: assert property (q.st == lpm_pkg::ST_RUN && is_halt && !dog_hit
    && !ah_en && q.ctl[lpm_pkg::LPM_AWU_BIT] |=> q.st == lpm_pkg::ST_AWU)
    else $error("halt did not enter auto-wake halt");
  dog_reset_a: assert property (q.st == lpm_pkg::ST_RUN && is_halt && dog_hit
    |=> wdg_rst && q.st == lpm_pkg::ST_RUN)
    else $error("watchdog halt reset missing");
  dog_quiet_a: assert property (is_halt && ah_en |=> !wdg_rst)
    else $error("watchdog reset in active-halt");
  // wake paths, settling, and the clocks of halt and active-halt
  ah_irq_a: assert property (q.st == lpm_pkg::ST_AH && !q.s2 && irq_rtc
    |=> irq_enter && clk_en.cpu)
    else $error("active-halt irq wake delayed");
  stab_hold_a: assert property (q.st == lpm_pkg::ST_STAB
    && q.cnt != lpm_pkg::LPM_STAB_END |=> q.st == lpm_pkg::ST_STAB && !clk_en.cpu)
    else $error("settling ended early");
  stab_start_a: assert property ($rose(q.st == lpm_pkg::ST_STAB) |-> q.cnt == 9'h000)
    else $error("settling count not cleared");
  stab_end_a: assert property (q.st == lpm_pkg::ST_STAB
    && q.cnt == lpm_pkg::LPM_STAB_END |=> clk_en.cpu && (fetch_rst != irq_enter))
    else $error("settling end without resume");
  halt_clk_a: assert property (q.st == lpm_pkg::ST_HALT |-> !clk_en.osc
    && !clk_en.periph) else $error("clocks live in halt");
  ah_clk_a: assert property (q.st == lpm_pkg::ST_AH |-> clk_en.osc && clk_en.timer
    && !clk_en.periph) else $error("wrong clocks in active-halt");
  // staying asleep, further wake paths, and the clock enables of settling and run
  wait_rst_a: assert property (q.st == lpm_pkg::ST_WAIT && q.s2
    |=> fetch_rst && !irq_enter && q.st == lpm_pkg::ST_RUN)
    else $error("reset pin did not end wait");
  wait_irq_a: assert property (q.st == lpm_pkg::ST_WAIT && !q.s2 && irq_any
    |=> irq_enter && clk_en.cpu)
    else $error("interrupt did not end wait");
  wait_hold_a: assert property (q.st == lpm_pkg::ST_WAIT && !q.s2 && !irq_any
    |=> q.st == lpm_pkg::ST_WAIT && !mask_clr && !wdg_rst)
    else $error("wait left without a wake event");
  ah_stay_a: assert property (q.st == lpm_pkg::ST_AH && !q.s2 && !irq_rtc && !irq_wrap
    |=> q.st == lpm_pkg::ST_AH)
    else $error("active-halt left without a timer wake");
  ah_rst_a: assert property (q.st == lpm_pkg::ST_AH && q.s2
    |=> q.st == lpm_pkg::ST_STAB && q.by_rst)
    else $error("active-halt reset wake skipped settling");
  halt_wake_a: assert property ((q.st == lpm_pkg::ST_HALT || q.st == lpm_pkg::ST_AWU)
    && !q.s2 && irq_halt_exit |=> q.st == lpm_pkg::ST_STAB && !q.by_rst && clk_en.osc)
    else $error("halt wake did not start settling");
  stab_clk_a: assert property (q.st == lpm_pkg::ST_STAB |-> clk_en.osc
    && !clk_en.periph && !clk_en.cpu)
    else $error("wrong clocks while settling");
  run_clk_a: assert property (q.st == lpm_pkg::ST_RUN |-> clk_en.cpu
    && clk_en.periph && clk_en.osc && clk_en.timer)
    else $error("clocks gated in run");

  wait_wake_c: cover property (q.st == lpm_pkg::ST_WAIT ##1 irq_enter);
  ah_wake_c:   cover property (q.st == lpm_pkg::ST_AH ##1 irq_enter);
  halt_rst_c:  cover property (q.st == lpm_pkg::ST_STAB && q.by_rst ##1 fetch_rst);
  wait_rst_c:  cover property (q.st == lpm_pkg::ST_WAIT ##1 fetch_rst);
  dog_rst_c:   cover property (is_halt && dog_hit ##1 wdg_rst);

endmodule

// [sim/lpm_cpu_model.sv]
/*
 * cpu core stand-in: issues executed opcodes, tracks the interrupt mask bit.
 * assumes the controller's pulses and its opcode input share aclk.
 */
`timescale 1ns/10ps
module lpm_cpu_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       mask_clr,
  input  wire logic       irq_enter,
  input  wire logic       fetch_rst,
  output      logic       op_valid,
  output      logic [7:0] opcode,
  output      logic       mask_q
);
  // quiet bus until the first instruction
  initial begin
    op_valid <= 1'h0;
    opcode   <= 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////
  // mask bit: set by reset or vector fetch, cleared on sleep entry
  always @(posedge aclk) begin
    if (!aresetn || fetch_rst || irq_enter) begin
      mask_q <= 1'h1;
    end else if (mask_clr) begin
      mask_q <= 1'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // one opcode for one cycle; returns at the edge that takes it
  task automatic issue(input logic [7:0] op);
    @(posedge aclk);
    op_valid <= 1'h1;
    opcode   <= op;
    @(posedge aclk);
    op_valid <= 1'h0;
    opcode   <= ~op;  // released bus shows no stale opcode
  endtask
endmodule

// [sim/low_power_mode_control_test.sv]
/*
 * self-checking bench of the low power mode controller.
 * assumes the cpu model above and a 200 MHz aclk.
 */
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module low_power_mode_control_test;
  logic              aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]        awaddr = 8'h00, araddr = 8'h00, opcode;
  logic [31:0]       wdata = 32'h0, rdata, rd_d;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic              rready = 1'h0, wdg_on = 1'h0, dog_sleep = 1'h0, wake_pin = 1'h0;
  logic              irq_any = 1'h0, irq_hx = 1'h0, irq_rtc = 1'h0, irq_wrap = 1'h0;
  logic              awready, wready, bvalid, arready, rvalid, op_valid, mask_q;
  logic              mask_clr, irq_enter, fetch_rst, wdg_rst;
  logic [1:0]        bresp, rresp, rd_r;
  logic [2:0]        mode;
  lpm_pkg::lpm_clk_t clk_en;
  int                fail_count = 0, checks = 0;
  always #2.5 aclk = ~aclk;
  lpm_ctrl #(.IDLE_OP(8'h8F)) lpm_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .op_valid(op_valid), .opcode(opcode),
    .wdg_on(wdg_on), .dog_sleep_option(dog_sleep), .wake_rst_pin(wake_pin),
    .irq_any(irq_any), .irq_halt_exit(irq_hx), .irq_rtc(irq_rtc), .irq_wrap(irq_wrap),
    .clk_en(clk_en), .mask_clr(mask_clr), .irq_enter(irq_enter), .fetch_rst(fetch_rst),
    .wdg_rst(wdg_rst), .mode(mode));
  lpm_cpu_model cpu_inst (.aclk(aclk), .aresetn(aresetn), .mask_clr(mask_clr),
    .irq_enter(irq_enter), .fetch_rst(fetch_rst), .op_valid(op_valid), .opcode(opcode),
    .mask_q(mask_q));
  ////////////////////////////////////////////////////////////////////////////
  // verdict, printed once
  task automatic test_done();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic stuck();
    fail_count++;
    test_done();
  endtask
  // bus write: address and data offered together, response held until seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
    end while (!(awready && wready) && n < 50);
    awvalid <= 1'h0; wvalid <= 1'h0;
    while (!bvalid && n < 50) begin
      @(posedge aclk);
      n++;
    end
    bready <= 1'h0;
    if (n >= 50) stuck();
    `CHK(bresp, er);
  endtask
  // bus read: data and response captured at the rvalid edge
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 50);
    arvalid <= 1'h0;
    while (!rvalid && n < 50) begin
      @(posedge aclk);
      n++;
    end
    rd_d = rdata; rd_r = rresp; rready <= 1'h0;
    if (n >= 50) stuck();
  endtask
  // sleep entry seen 1 ns after the taking edge
  task automatic sleep(input logic [7:0] op, input logic [2:0] m);
    cpu_inst.issue(op);
    #1;
    `CHK(mode, m);
    `CHK(mask_clr, 1'h1);
  endtask
  // settling phase must last exactly 256 cycles, then one resume pulse
  task automatic settle(input logic by_rst);
    int n;
    n = 0;
    while (mode !== 3'h4 && n < 10) begin @(posedge aclk); #1; n++; end
    `CHK(mode, 3'h4);
    n = 0;
    while (mode === 3'h4 && n < 300) begin @(posedge aclk); #1; n++; end
    `CHK(n, 256);
    `CHK({irq_enter, fetch_rst}, by_rst ? 2'h1 : 2'h2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(lpm_pkg::LPM_CTRL_ADDR);
    `CHK(rd_d, 32'h0);
    axi_wr(lpm_pkg::LPM_CTRL_ADDR, 32'hFFFFFFFF, lpm_pkg::LPM_OKAY);
    axi_rd(lpm_pkg::LPM_CTRL_ADDR);
    `CHK(rd_d, 32'h1F);
    axi_rd(lpm_pkg::LPM_STAT_ADDR);
    `CHK(rd_d, 32'h10);
    axi_wr(lpm_pkg::LPM_STAT_ADDR, 32'h0, lpm_pkg::LPM_OKAY);
    axi_wr(8'h08, 32'h0, lpm_pkg::LPM_SLVERR);
    axi_rd(8'h0C);
    `CHK({rd_r, rd_d}, {lpm_pkg::LPM_SLVERR, 32'h0});
    axi_wr(lpm_pkg::LPM_CTRL_ADDR, 32'h0C, lpm_pkg::LPM_OKAY);
  endtask
  // wait: cpu stopped, peripherals on, an interrupt or the wake reset pin ends it
  task automatic t_wait();
    sleep(8'h8F, 3'h1);
    `CHK(clk_en, 4'h7);
    cpu_inst.issue(lpm_pkg::LPM_OP_HALT);
    #1;
    `CHK({mode, mask_q}, 4'h2);
    @(posedge aclk); irq_any <= 1'h1;
    @(posedge aclk); #1;
    `CHK({mode, irq_enter}, 4'h1);
    @(posedge aclk); irq_any <= 1'h0;
    axi_rd(lpm_pkg::LPM_CTRL_ADDR);
    `CHK(rd_d, 32'h0C);
    // the wake reset pin ends wait with a reset fetch after its synchroniser
    sleep(8'h8F, 3'h1);
    @(posedge aclk); wake_pin <= 1'h1;
    repeat (3) @(posedge aclk);
    #1;
    `CHK({mode, fetch_rst, irq_enter}, 5'h02);
    @(posedge aclk); wake_pin <= 1'h0;
  endtask
  // every timer setting: wrong wake ignored, right wake resumes
  task automatic t_select();
    logic [3:0] c;
    logic       ah;
    for (int i = 0; i < 16; i++) begin
      c  = 4'(i);
      ah = c[0] | (c[1] & c[2] & ~c[3]);
      axi_wr(lpm_pkg::LPM_CTRL_ADDR, 32'(c), lpm_pkg::LPM_OKAY);
      sleep(lpm_pkg::LPM_OP_HALT, ah ? 3'h2 : 3'h3);
      `CHK(clk_en, ah ? 4'h3 : 4'h0);
      @(posedge aclk); irq_hx <= ah; irq_rtc <= !ah;
      @(posedge aclk); #1;
      `CHK(mode, ah ? 3'h2 : 3'h3);
      @(posedge aclk); irq_hx <= !ah; irq_rtc <= ah & c[0]; irq_wrap <= ah & ~c[0];
      if (ah) begin
        @(posedge aclk); #1;
        `CHK({mode, irq_enter}, 4'h1);
      end else begin
        settle(1'h0);
      end
      // pending flags cleared before the next halt
      @(posedge aclk); irq_hx <= 1'h0; irq_rtc <= 1'h0; irq_wrap <= 1'h0;
    end
  endtask
  // interrupt already pending at entry wakes at once
  task automatic t_pending();
    axi_wr(lpm_pkg::LPM_CTRL_ADDR, 32'h0, lpm_pkg::LPM_OKAY);
    @(posedge aclk); irq_hx <= 1'h1;
    sleep(lpm_pkg::LPM_OP_HALT, 3'h3);
    settle(1'h0);
    @(posedge aclk); irq_hx <= 1'h0;
  endtask
  // watchdog reset on halt, then active-halt left through a long reset pulse
  task automatic t_dog();
    @(posedge aclk); wdg_on <= 1'h1;
    cpu_inst.issue(lpm_pkg::LPM_OP_HALT);
    #1;
    `CHK({wdg_rst, mode}, 4'h8);
    axi_wr(lpm_pkg::LPM_CTRL_ADDR, 32'h1, lpm_pkg::LPM_OKAY);
    cpu_inst.issue(lpm_pkg::LPM_OP_HALT);
    #1;
    `CHK({wdg_rst, mode}, 4'h2);
    @(posedge aclk); wake_pin <= 1'h1;  // held beyond 42 us
    settle(1'h1);
    repeat (8200) @(posedge aclk);
    wake_pin <= 1'h0; wdg_on <= 1'h0;
    axi_rd(lpm_pkg::LPM_STAT_ADDR);
    `CHK(rd_d, 32'h18);
  endtask
  // watchdog option set: halt goes ahead, then a long reset pulse ends it
  task automatic t_opt();
    axi_wr(lpm_pkg::LPM_CTRL_ADDR, 32'h0, lpm_pkg::LPM_OKAY);
    @(posedge aclk); wdg_on <= 1'h1; dog_sleep <= 1'h1;
    sleep(lpm_pkg::LPM_OP_HALT, 3'h3);
    `CHK(wdg_rst, 1'h0);
    @(posedge aclk); wake_pin <= 1'h1;  // held beyond 42 us
    settle(1'h1);
    repeat (8200) @(posedge aclk);
    wake_pin <= 1'h0; wdg_on <= 1'h0; dog_sleep <= 1'h0;
    axi_rd(lpm_pkg::LPM_STAT_ADDR);
    `CHK(rd_d, 32'h08);
  endtask
  // self wake selected: auto-wake variant, left like halt
  task automatic t_awu();
    axi_wr(lpm_pkg::LPM_CTRL_ADDR, 32'h10, lpm_pkg::LPM_OKAY);
    sleep(lpm_pkg::LPM_OP_HALT, 3'h5);
    `CHK(clk_en, 4'h0);
    @(posedge aclk); irq_hx <= 1'h1;
    settle(1'h0);
    @(posedge aclk); irq_hx <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk); #1;
    `CHK({mode, clk_en}, 7'h0F);
    t_regs();
    t_wait();
    t_select();
    t_pending();
    t_dog();
    t_opt();
    t_awu();
    test_done();
  end
endmodule
